// ===== dtmc_top.sv
`timescale 1ns/1ps
module dtmc_top #(
    parameter int CHANNELS = dtmc_pkg::CHANNELS,
    parameter int CODE_W = dtmc_pkg::CODE_W
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_output_load_strobe_n,
    output logic [CHANNELS-2:0][CODE_W-1:0] o_channel_code,
    output logic [CODE_W-1:0] o_last_channel_output,
    output logic o_last_channel_oe_n,
    output logic o_reference_value_select,
    output logic o_internal_reference_select
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [dtmc_pkg::CTRL_W-1:0] ctrl;
        logic [CHANNELS-1:0][CODE_W-1:0] data_a;
        logic [CHANNELS-1:0][CODE_W-1:0] data_b;
        logic [CHANNELS-1:0][CODE_W-1:0] out_code;
        logic [CHANNELS-1:0] use_b;
        logic [dtmc_pkg::GROUPS-1:0] fresh;
        logic [5:0] mon_sel;
        logic [CODE_W-1:0] mon_code;
        logic mon_oe_n;
        logic [dtmc_pkg::CMD_W-1:0] cmd;
        logic [5:0] rd_sel;
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
    } dtmc_state_t;

    dtmc_state_t st_reg;
    dtmc_state_t st_next;

    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic load_pulse;
    logic sw_load;
    logic exec;
    logic [31:0] cmd_word;
    logic [31:0] rdsel_word;
    logic [1:0] cmd_dest;
    logic [5:0] cmd_addr;
    logic [CODE_W-1:0] cmd_data;
    logic [2:0] grp;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] dtmc_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : dtmc_merge

    function automatic logic dtmc_chan_ok(input logic [5:0] ch);
        return 32'(ch) < CHANNELS;
    endfunction : dtmc_chan_ok

    function automatic logic [2:0] dtmc_group(input logic [5:0] ch);
        return ch[5:3];
    endfunction : dtmc_group

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    dtmc_axil_slave u_bus (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_awaddr(i_s_axi_awaddr),
        .i_awvalid(i_s_axi_awvalid),
        .o_awready(o_s_axi_awready),
        .i_wdata(i_s_axi_wdata),
        .i_wstrb(i_s_axi_wstrb),
        .i_wvalid(i_s_axi_wvalid),
        .o_wready(o_s_axi_wready),
        .o_bresp(o_s_axi_bresp),
        .o_bvalid(o_s_axi_bvalid),
        .i_bready(i_s_axi_bready),
        .i_araddr(i_s_axi_araddr),
        .i_arvalid(i_s_axi_arvalid),
        .o_arready(o_s_axi_arready),
        .o_rdata(o_s_axi_rdata),
        .o_rresp(o_s_axi_rresp),
        .o_rvalid(o_s_axi_rvalid),
        .i_rready(i_s_axi_rready),
        .o_wr_fire(wr_fire),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_wr_strb(wr_strb),
        .i_wr_err(wr_err),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data),
        .i_rd_err(rd_err)
    );

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        case (rd_addr)
            dtmc_pkg::OFF_CMD: begin
                rd_data = 32'(st_reg.cmd);
            end
            dtmc_pkg::OFF_CTRL: begin
                rd_data = 32'(st_reg.ctrl);
            end
            dtmc_pkg::OFF_STATUS: begin
                rd_data = {19'h00000, st_reg.mon_oe_n, 1'b0, st_reg.fresh, st_reg.mon_sel};
            end
            dtmc_pkg::OFF_RDSEL: begin
                rd_data = 32'(st_reg.rd_sel);
            end
            dtmc_pkg::OFF_RDDATA: begin
                if (dtmc_chan_ok(st_reg.rd_sel)) begin
                    rd_data = {4'h0, st_reg.data_b[st_reg.rd_sel],
                               4'h0, st_reg.data_a[st_reg.rd_sel]};
                end
            end
            dtmc_pkg::OFF_RDOUT: begin
                if (dtmc_chan_ok(st_reg.rd_sel)) begin
                    rd_data = {st_reg.use_b[st_reg.rd_sel], 19'h00000,
                               st_reg.out_code[st_reg.rd_sel]};
                end
            end
            dtmc_pkg::OFF_LOAD: begin
                rd_data = 32'h00000000;
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    always_comb begin
        wr_err = 1'b0;
        exec = 1'b0;
        sw_load = 1'b0;
        cmd_word = dtmc_merge(32'(st_reg.cmd), wr_data, wr_strb);
        rdsel_word = dtmc_merge(32'(st_reg.rd_sel), wr_data, wr_strb);
        case (wr_addr)
            dtmc_pkg::OFF_CMD: begin
                exec = wr_fire;
            end
            dtmc_pkg::OFF_RDSEL: begin
                wr_err = 1'b0;
            end
            dtmc_pkg::OFF_LOAD: begin
                sw_load = wr_fire && wr_strb[0] && wr_data[0];
            end
            default: begin
                wr_err = 1'b1;
            end
        endcase
        cmd_dest = cmd_word[dtmc_pkg::CMD_DEST_LSB +: 2];
        cmd_addr = cmd_word[dtmc_pkg::CMD_ADDR_LSB +: 6];
        cmd_data = cmd_word[dtmc_pkg::CMD_DATA_LSB +: CODE_W];
        grp = dtmc_group(cmd_addr);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // load strobe pin synchroniser, falling edge is the strobe
        st_next.strobe_meta = i_output_load_strobe_n;
        st_next.strobe_sync = st_reg.strobe_meta;
        st_next.strobe_prev = st_reg.strobe_sync;
        load_pulse = (st_reg.strobe_prev && !st_reg.strobe_sync) || sw_load;

        if (wr_fire && wr_addr == dtmc_pkg::OFF_RDSEL) begin
            st_next.rd_sel = rdsel_word[5:0];
        end

        // command execution
        if (exec) begin
            st_next.cmd = cmd_word[dtmc_pkg::CMD_W-1:0];
            case (cmd_dest)
                dtmc_pkg::DEST_SFR: begin
                    if (cmd_addr == dtmc_pkg::ADDR_CTRL) begin
                        st_next.ctrl = cmd_data[dtmc_pkg::CTRL_W-1:0];
                    end else if (cmd_addr == dtmc_pkg::ADDR_MON_SEL
                                 && st_reg.ctrl[dtmc_pkg::CTRL_MON_EN]) begin
                        st_next.mon_sel = cmd_data[5:0];
                    end
                end
                dtmc_pkg::DEST_A: begin
                    if (dtmc_chan_ok(cmd_addr)) begin
                        st_next.data_a[cmd_addr] = cmd_data;
                    end
                end
                dtmc_pkg::DEST_B: begin
                    if (dtmc_chan_ok(cmd_addr)
                        && st_reg.ctrl[dtmc_pkg::CTRL_TOG_LSB + 32'(grp)]) begin
                        st_next.data_b[cmd_addr] = cmd_data;
                    end
                end
                default: begin
                    st_next.cmd = cmd_word[dtmc_pkg::CMD_W-1:0];
                end
            endcase
        end

        // output update on the load strobe
        if (load_pulse) begin
            for (int ch = 0; ch < CHANNELS; ch++) begin
                if (st_reg.ctrl[dtmc_pkg::CTRL_TOG_LSB + ch / 8]) begin
                    if (st_reg.fresh[ch / 8] || st_reg.use_b[ch]) begin
                        st_next.out_code[ch] = st_reg.data_a[ch];
                        st_next.use_b[ch] = 1'b0;
                    end else begin
                        st_next.out_code[ch] = st_reg.data_b[ch];
                        st_next.use_b[ch] = 1'b1;
                    end
                end else begin
                    st_next.out_code[ch] = st_reg.data_a[ch];
                    st_next.use_b[ch] = 1'b0;
                end
            end
            for (int g = 0; g < dtmc_pkg::GROUPS; g++) begin
                if (st_reg.ctrl[dtmc_pkg::CTRL_TOG_LSB + g]) begin
                    st_next.fresh[g] = 1'b0;
                end
            end
        end

        // a disabled group restarts from A when enabled again
        for (int g = 0; g < dtmc_pkg::GROUPS; g++) begin
            if (!st_next.ctrl[dtmc_pkg::CTRL_TOG_LSB + g]) begin
                st_next.fresh[g] = 1'b1;
            end
        end

        // monitor routing on the last channel pin
        if (!st_next.ctrl[dtmc_pkg::CTRL_MON_EN]) begin
            st_next.mon_sel = dtmc_pkg::MON_OFF;
            st_next.mon_code = st_next.out_code[CHANNELS-1];
            st_next.mon_oe_n = 1'b0;
        end else if (dtmc_chan_ok(st_next.mon_sel)) begin
            st_next.mon_code = st_next.out_code[st_next.mon_sel];
            st_next.mon_oe_n = 1'b0;
        end else begin
            st_next.mon_code = '0;
            st_next.mon_oe_n = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '{ctrl: dtmc_pkg::CTRL_RST,
                        fresh: '1,
                        mon_sel: dtmc_pkg::MON_OFF,
                        cmd: dtmc_pkg::CMD_RST,
                        rd_sel: dtmc_pkg::RDSEL_RST,
                        strobe_meta: 1'b1,
                        strobe_sync: 1'b1,
                        strobe_prev: 1'b1,
                        default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_channel_code = st_reg.out_code[CHANNELS-2:0];
    assign o_last_channel_output = st_reg.mon_code;
    assign o_last_channel_oe_n = st_reg.mon_oe_n;
    assign o_reference_value_select = st_reg.ctrl[dtmc_pkg::CTRL_REF_VAL];
    assign o_internal_reference_select = st_reg.ctrl[dtmc_pkg::CTRL_INT_REF];

endmodule : dtmc_top

// ===== dtmc_pkg.sv
package dtmc_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int CHANNELS = 40;
    localparam int GROUPS = 5;
    localparam int CODE_W = 12;
    localparam int CTRL_W = 11;
    localparam int CMD_W = 26;
    localparam int AXI_AW = 8;

    // ------------------------------------------------------------------
    // bus register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RDSEL = 8'h0C;
    localparam logic [7:0] OFF_RDDATA = 8'h10;
    localparam logic [7:0] OFF_LOAD = 8'h14;
    localparam logic [7:0] OFF_RDOUT = 8'h18;

    // ------------------------------------------------------------------
    // write command word layout
    // ------------------------------------------------------------------
    localparam int CMD_DATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 16;
    localparam int CMD_DEST_LSB = 24;
    localparam logic [1:0] DEST_SFR = 2'h0;
    localparam logic [1:0] DEST_B = 2'h2;
    localparam logic [1:0] DEST_A = 2'h3;
    localparam logic [5:0] ADDR_CTRL = 6'h0C;
    localparam logic [5:0] ADDR_MON_SEL = 6'h0D;
    localparam logic [5:0] MON_OFF = 6'h3F;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_TOG_LSB = 0;
    localparam int CTRL_INT_REF = 8;
    localparam int CTRL_MON_EN = 9;
    localparam int CTRL_REF_VAL = 10;

    // ------------------------------------------------------------------
    // reset values and responses
    // ------------------------------------------------------------------
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
    localparam logic [CMD_W-1:0] CMD_RST = 26'h0000000;
    localparam logic [5:0] RDSEL_RST = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dtmc_pkg

// ===== dtmc_axil_slave.sv
`timescale 1ns/1ps
module dtmc_axil_slave (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic o_wr_fire,
    output logic [7:0] o_wr_addr,
    output logic [31:0] o_wr_data,
    output logic [3:0] o_wr_strb,
    input wire logic i_wr_err,
    output logic [7:0] o_rd_addr,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_err
);

    typedef struct packed {
        logic aw_full;
        logic [7:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dtmc_axil_t;

    dtmc_axil_t s_reg;
    dtmc_axil_t s_next;

    // ------------------------------------------------------------------
    // channel handshakes
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        if (i_awvalid && s_reg.awready) begin
            s_next.aw_full = 1'b1;
            s_next.awaddr = i_awaddr;
        end
        if (i_wvalid && s_reg.wready) begin
            s_next.w_full = 1'b1;
            s_next.wdata = i_wdata;
            s_next.wstrb = i_wstrb;
        end
        if (s_reg.bvalid && i_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (o_wr_fire) begin
            s_next.aw_full = 1'b0;
            s_next.w_full = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = i_wr_err ? dtmc_pkg::RESP_SLVERR : dtmc_pkg::RESP_OKAY;
        end
        if (s_reg.rvalid && i_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (i_arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = i_rd_err ? 32'h00000000 : i_rd_data;
            s_next.rresp = i_rd_err ? dtmc_pkg::RESP_SLVERR : dtmc_pkg::RESP_OKAY;
        end
        s_next.awready = !s_next.aw_full && !s_next.bvalid;
        s_next.wready = !s_next.w_full && !s_next.bvalid;
        s_next.arready = !s_next.rvalid;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_reg <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_wr_fire = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;
    assign o_wr_addr = s_reg.awaddr;
    assign o_wr_data = s_reg.wdata;
    assign o_wr_strb = s_reg.wstrb;
    assign o_rd_addr = i_araddr;
    assign o_awready = s_reg.awready;
    assign o_wready = s_reg.wready;
    assign o_bvalid = s_reg.bvalid;
    assign o_bresp = s_reg.bresp;
    assign o_arready = s_reg.arready;
    assign o_rvalid = s_reg.rvalid;
    assign o_rdata = s_reg.rdata;
    assign o_rresp = s_reg.rresp;

endmodule : dtmc_axil_slave

// ===== dtmc_checker.sv
`timescale 1ns/1ps
module dtmc_checker #(
    parameter int CHANNELS = 40,
    parameter int CODE_W = 12
) (
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic o_s_axi_rvalid,
    input wire logic i_output_load_strobe_n,
    input wire logic [CHANNELS-2:0][CODE_W-1:0] o_channel_code,
    input wire logic [CODE_W-1:0] o_last_channel_output,
    input wire logic o_last_channel_oe_n,
    input wire logic o_reference_value_select,
    input wire logic o_internal_reference_select
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    AST_REF_RST: assert property (
        $rose(i_arst_n) |-> !o_internal_reference_select && !o_reference_value_select)
        else $error("reference not external after reset");
    AST_REF_WR: assert property (
        $changed({o_internal_reference_select, o_reference_value_select}) |-> o_s_axi_bvalid)
        else $error("reference select changed without a write");
    AST_MON_RST: assert property (
        $rose(i_arst_n) |-> !o_last_channel_oe_n)
        else $error("last channel pin not driven after reset");
    AST_CODE_LOAD: assert property (
        $changed(o_channel_code) |-> o_s_axi_bvalid || !$past(i_output_load_strobe_n, 2)
        || !$past(i_output_load_strobe_n, 3) || !$past(i_output_load_strobe_n, 4))
        else $error("channel code changed without load");
    AST_MON_HOLD: assert property (
        $changed({o_last_channel_output, o_last_channel_oe_n}) |-> o_s_axi_bvalid
        || !$past(i_output_load_strobe_n, 2) || !$past(i_output_load_strobe_n, 3)
        || !$past(i_output_load_strobe_n, 4))
        else $error("monitor pin changed without write or load");
    AST_B_ANSWER: assert property (
        i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
        |-> ##[1:2] o_s_axi_bvalid)
        else $error("write response late");
    AST_B_BUSY: assert property (
        o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write ready while response pending");
    AST_B_CLEAR: assert property (
        o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
        else $error("write response not retired");
    AST_R_ANSWER: assert property (
        i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read data late");
endmodule : dtmc_checker

bind dtmc_top dtmc_checker #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_chk (
    .i_clk(i_clk), .i_arst_n(i_arst_n),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_output_load_strobe_n(i_output_load_strobe_n),
    .o_channel_code(o_channel_code), .o_last_channel_output(o_last_channel_output),
    .o_last_channel_oe_n(o_last_channel_oe_n),
    .o_reference_value_select(o_reference_value_select),
    .o_internal_reference_select(o_internal_reference_select)
);

// ===== dtmc_host_strobe.sv
`timescale 1ns/1ps
module dtmc_host_strobe (
    input wire logic i_clk,
    input wire logic i_fire,
    output logic o_output_load_strobe_n
);
    logic [1:0] low_reg = 2'h0;
    // low for three cycles, then high until asked again
    always_ff @(posedge i_clk) begin
        if (i_fire) low_reg <= 2'h3;
        else if (low_reg != 2'h0) low_reg <= low_reg - 2'h1;
    end
    assign o_output_load_strobe_n = (low_reg == 2'h0);
endmodule : dtmc_host_strobe

// ===== dac_toggle_monitor_control_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module dac_toggle_monitor_control_bench;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic fire = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, strobe_n, oe_n, int_ref, ref_val;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [38:0][11:0] code;
    logic [11:0] last;
    int n_fail = 0;
    int samples_checked = 0;
    // ------------------------------------------------------------------
    // design and host strobe
    // ------------------------------------------------------------------
    dtmc_top dut (.i_clk(clk), .i_arst_n(rst_n), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .i_output_load_strobe_n(strobe_n), .o_channel_code(code),
        .o_last_channel_output(last), .o_last_channel_oe_n(oe_n),
        .o_reference_value_select(ref_val), .o_internal_reference_select(int_ref));
    dtmc_host_strobe u_host (.i_clk(clk), .i_fire(fire), .o_output_load_strobe_n(strobe_n));
    initial begin
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // bus and strobe tasks
    // ------------------------------------------------------------------
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'h0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        @(posedge clk);
    endtask : axr
    task automatic cmd(input logic [1:0] dst, input logic [5:0] adr, input logic [11:0] dat);
        logic [1:0] r;
        axw(dtmc_pkg::OFF_CMD, {6'h00, dst, 2'h0, adr, 4'h0, dat}, r);
    endtask : cmd
    task automatic ctl(input logic [11:0] dat);
        cmd(dtmc_pkg::DEST_SFR, dtmc_pkg::ADDR_CTRL, dat);
    endtask : ctl
    task automatic mon(input logic [5:0] s);
        cmd(dtmc_pkg::DEST_SFR, dtmc_pkg::ADDR_MON_SEL, {6'h00, s});
    endtask : mon
    task automatic strb();
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (8) @(posedge clk);
    endtask : strb
    task automatic do_reset();
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
    endtask : do_reset
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        `CHK(int_ref, 1'h0)
        `CHK(ref_val, 1'h0)
        `CHK(oe_n, 1'h0)
        `CHK(code[0], 12'h000)
    endtask : t_reset
    task automatic t_ctrl();
        logic [31:0] d;
        logic [1:0] r;
        cmd(2'h1, dtmc_pkg::ADDR_CTRL, 12'h500);
        `CHK(int_ref, 1'h0)
        cmd(dtmc_pkg::DEST_SFR, 6'h0B, 12'h500);
        `CHK(int_ref, 1'h0)
        ctl(12'h500);
        `CHK(int_ref, 1'h1)
        `CHK(ref_val, 1'h1)
        ctl(12'h100);
        `CHK(ref_val, 1'h0)
        axr(dtmc_pkg::OFF_CTRL, d, r);
        `CHK(d, 32'h00000100)
    endtask : t_ctrl
    task automatic t_toggle();
        logic [5:0] ch [3] = '{6'h07, 6'h08, 6'h26};
        logic [11:0] av [3] = '{12'h123, 12'h111, 12'h3C3};
        logic [11:0] bv [3] = '{12'h456, 12'h222, 12'hC3C};
        logic [1:0] r;
        ctl(12'h011);
        for (int i = 0; i < 3; i++) cmd(dtmc_pkg::DEST_A, ch[i], av[i]);
        for (int i = 0; i < 3; i++) cmd(dtmc_pkg::DEST_B, ch[i], bv[i]);
        for (int k = 0; k < 4; k++) begin
            if (k == 3) axw(dtmc_pkg::OFF_LOAD, 32'h00000001, r);
            else strb();
            `CHK(code[7], (k % 2) ? bv[0] : av[0])
            `CHK(code[8], av[1])
            `CHK(code[38], (k % 2) ? bv[2] : av[2])
        end
        ctl(12'h002);
        strb();
        `CHK(code[7], av[0])
        `CHK(code[8], av[1])
        strb();
        `CHK(code[8], 12'h000)
    endtask : t_toggle
    task automatic t_monitor();
        logic [5:0] sel [3] = '{6'h07, 6'h26, 6'h27};
        logic [11:0] val [3] = '{12'h123, 12'h3C3, 12'h5A5};
        cmd(dtmc_pkg::DEST_A, 6'h27, 12'h5A5);
        mon(6'h07);
        strb();
        `CHK(last, 12'h5A5)
        ctl(12'h200);
        `CHK(oe_n, 1'h1)
        for (int i = 0; i < 3; i++) begin
            mon(sel[i]);
            `CHK(last, val[i])
            `CHK(oe_n, 1'h0)
        end
        mon(6'h3F);
        `CHK(oe_n, 1'h1)
        mon(6'h10);
        cmd(dtmc_pkg::DEST_A, 6'h10, 12'h777);
        strb();
        `CHK(last, 12'h777)
        ctl(12'h000);
        `CHK(oe_n, 1'h0)
        `CHK(last, 12'h5A5)
    endtask : t_monitor
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0] r;
        axw(dtmc_pkg::OFF_RDSEL, 32'h00000026, r);
        axr(dtmc_pkg::OFF_RDDATA, d, r);
        `CHK(d, 32'h0C3C03C3)
        axr(dtmc_pkg::OFF_RDOUT, d, r);
        `CHK(d, 32'h000003C3)
        axr(8'h40, d, r);
        `CHK(r, dtmc_pkg::RESP_SLVERR)
        `CHK(d, 32'h00000000)
        axw(dtmc_pkg::OFF_CTRL, 32'h00000100, r);
        `CHK(r, dtmc_pkg::RESP_SLVERR)
        `CHK(int_ref, 1'h0)
    endtask : t_bus
    initial begin
        do_reset();
        t_reset();
        t_ctrl();
        do_reset();
        t_reset();
        t_toggle();
        t_monitor();
        t_bus();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
endmodule : dac_toggle_monitor_control_bench
